// ==== verilog/sleep_idle_power_control.sv ====
// What this block does
// - Idle and Sleep both gate the CPU clock, any source selected.
// - Idle keeps the system clock source running for peripherals.
// - Peripherals with stop_in_idle set halt in Idle; others run.
// - Halt instruction with sleep_on_wait_select clear enters Idle.
// - Interrupt above CPU priority wakes Idle; lower or equal stays idle.
// - Any reset or watchdog time-out also ends Idle.
// - Sleep stops CPU, system source and its peripherals.
// - Clock failure monitor off in Sleep; brownout circuit stays on.
// - Watchdog count is not cleared when entering Sleep.
// - Pin change, watchdog, converter, serial, low power units may run.
// - Pins keep their driven levels during Sleep.
// - USB can keep the primary or fast oscillator on in Sleep.
// - Sleep wakes on higher priority interrupt, reset, watchdog time-out.
// - Low priority Sleep wake restarts peripheral clock, goes to Idle.
// - Restarting crystal or PLL source waits start-up and lock delay on a higher priority Sleep wake only.
// - Sleep exit may wait on oscillator; Idle exit adds none.
// - Software selects the run clock among internal, primary, PLL and secondary sources.
// - Peripherals run at a programmable fraction of core clock.
// - Peripheral divisor gives ratios one, two, four, eight.
//
// Added by the designer: the APB slave port and the address map.
`timescale 1ns/1ps
`default_nettype none
module sleep_idle_power_control
    import power_ctl_pkg::*;
#(
    parameter int NUM_PERIPH    = 8,
    parameter int OSC_START_CNT = power_ctl_pkg::OSC_START_CYC,
    parameter int PLL_LOCK_CNT  = power_ctl_pkg::PLL_LOCK_CYC
) (
    input  wire logic                               clk,
    input  wire logic                               rst_n,
    // APB slave
    input  wire logic                               psel,
    input  wire logic                               penable,
    input  wire logic                               pwrite,
    input  wire logic [7:0]                         paddr,
    input  wire logic [31:0]                        pwdata,
    output logic [31:0]                             prdata,
    output logic                                    pready,
    output logic                                    pslverr,
    // CPU core and interrupt controller
    input  wire logic                               haltInstr,
    input  wire logic                               irqPending,
    input  wire logic [power_ctl_pkg::PRIO_W-1:0]   irqPriority,
    input  wire logic                               irqSleepCapable,
    input  wire logic [power_ctl_pkg::PRIO_W-1:0]   cpuPriority,
    input  wire logic                               watchdogTimeout,
    input  wire logic                               usbOscRequest,
    // Clock gating outputs
    output logic                                    cpuClkEn,
    output logic                                    sysSourceEn,
    output logic [power_ctl_pkg::SRC_W-1:0]         clkSource,
    output logic                                    periphTick,
    output logic [NUM_PERIPH-1:0]                   periphRun,
    output logic                                    sleepPeriphRun,
    output logic                                    clockMonitorEn,
    output logic                                    brownoutEn,
    output logic                                    watchdogClear,
    output logic                                    padHold,
    output logic                                    inIdle,
    output logic                                    inSleep
);
    import power_ctl_pkg::*;

    // ------------------------------------------------------------
    // Registers and state
    // ------------------------------------------------------------
    logic [31:0]           oscCtrl;
    logic [NUM_PERIPH-1:0] stopInIdle;
    power_state_t          state;
    power_state_t          next_state;
    logic [DELAY_W-1:0]    delayCount;
    logic [SRC_W-1:0]      activeSrc;
    logic                  wakeHigh;
    logic                  wakeLow;
    logic                  sourceNeedsStart;
    logic                  crystalStart;
    logic                  pllLock;
    logic [DELAY_W-1:0]    restartCycles;
    logic                  apbWrite;
    logic                  apbRead;

    // ------------------------------------------------------------
    // APB access decode
    // ------------------------------------------------------------
    // Access phase only; the setup cycle changes no control register
    assign apbWrite = psel && penable && pwrite;
    assign apbRead  = psel && penable && !pwrite;

    // Zero-wait slave; unmapped reads give zero with an error
    assign pready  = 1'b1;
    assign pslverr = (apbWrite || apbRead) &&
                     (paddr != OSC_CTRL_ADDR) && (paddr != STOP_IDLE_ADDR) && (paddr != STATUS_ADDR);

    // ------------------------------------------------------------
    // Register writes
    // ------------------------------------------------------------
    // software source select; divisor field; sleep select bit
    // Whole word taken; this bus carries no byte strobes
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            oscCtrl <= OSC_CTRL_RESET;
        end else if (apbWrite && paddr == OSC_CTRL_ADDR) begin
            oscCtrl <= pwdata;
        end
    end

    // Per-peripheral stop-in-idle bits
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            stopInIdle <= '0;
        end else if (apbWrite && paddr == STOP_IDLE_ADDR) begin
            stopInIdle <= pwdata[NUM_PERIPH-1:0];
        end
    end

    // Read mux, registered data
    // Loaded in the setup cycle so data stands at the access edge
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            prdata <= 32'h0000_0000;
        end else if (psel && !penable && !pwrite) begin
            case (paddr)
                OSC_CTRL_ADDR:  prdata <= oscCtrl;
                STOP_IDLE_ADDR: prdata <= 32'(stopInIdle);
                STATUS_ADDR:    prdata <= {24'h00_0000, 1'b0, activeSrc, state};
                default:        prdata <= 32'h0000_0000;
            endcase
        end
    end

    // ------------------------------------------------------------
    // Wake qualification
    // ------------------------------------------------------------
    // strict priority compare; sleep-capable sources only in Sleep
    assign wakeHigh = watchdogTimeout ||
                      (irqPending && irqPriority > cpuPriority &&
                       (state != SLEEP || irqSleepCapable));
    assign wakeLow  = irqPending && irqSleepCapable && irqPriority <= cpuPriority;

    // ------------------------------------------------------------
    // Restart cost of the source that was stopped
    // ------------------------------------------------------------
    // crystal needs start-up, PLL needs lock, primary with PLL both
    // Looks at the source in use, not the register, which software may
    // have rewritten while the CPU was halted
    assign crystalStart     = (activeSrc == SRC_PRIMARY) || (activeSrc == SRC_PRIM_PLL);
    assign pllLock          = (activeSrc == SRC_FAST_PLL) || (activeSrc == SRC_PRIM_PLL);
    assign sourceNeedsStart = crystalStart || pllLock;
    // Internal oscillators come back at once and add no wait
    assign restartCycles    = (crystalStart ? DELAY_W'(OSC_START_CNT) : '0) +
                              (pllLock ? DELAY_W'(PLL_LOCK_CNT) : '0);

    // ------------------------------------------------------------
    // Power state machine
    // ------------------------------------------------------------
    always_comb begin
        next_state = state;
        case (state)
            RUN: begin
                if (haltInstr) begin
                    next_state = oscCtrl[SLEEP_SEL_BIT] ? SLEEP : IDLE;
                end
            end
            IDLE: begin
                // idle exit direct, no start-up wait
                if (wakeHigh) begin
                    next_state = RUN;
                end
            end
            SLEEP: begin
                if (wakeHigh) begin
                    next_state = WAKE;
                end else if (wakeLow) begin
                    next_state = IDLE;
                end
            end
            WAKE: begin
                // Restart wait runs out before the CPU clock returns
                if (delayCount == '0) begin
                    next_state = RUN;
                end
            end
            default: next_state = RUN;
        endcase
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            state <= RUN;
        end else begin
            state <= next_state;
        end
    end

    // ------------------------------------------------------------
    // Oscillator restart delay
    // ------------------------------------------------------------
    // start-up plus lock; only on Sleep exit
    // A source kept on by USB never stopped, so it restarts with no wait
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            delayCount <= '0;
        end else if (state == SLEEP && next_state != SLEEP) begin
            if (sourceNeedsStart && !sysSourceEn) begin
                delayCount <= restartCycles;
            end else begin
                delayCount <= '0;
            end
        end else if (delayCount != '0) begin
            delayCount <= DELAY_W'(delayCount - 1'b1);
        end
    end

    // Source actually in use; selection kept across low power
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            activeSrc <= SRC_FAST_INT;
        end else if (state == RUN) begin
            activeSrc <= oscCtrl[SRC_LSB +: SRC_W];
        end
    end
    assign clkSource = activeSrc;

    // ------------------------------------------------------------
    // Clock gates and companion enables
    // ------------------------------------------------------------
    // CPU clock only in run
    // Follows the next state so the gate moves with the state
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            cpuClkEn <= 1'b1;
        end else begin
            cpuClkEn <= (next_state == RUN);
        end
    end

    // source on in Idle; off in Sleep; USB hold
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            sysSourceEn <= 1'b1;
        end else begin
            sysSourceEn <= (next_state != SLEEP) ||
                           (usbOscRequest && oscCtrl[USB_HOLD_BIT]);
        end
    end

    // peripheral fraction; ratio select; restarts outside Sleep
    // Held while the source is stopped or restarting
    ratio_divider u_div (
        .clk      (clk),
        .rst_n    (rst_n),
        .run      (state != SLEEP && state != WAKE),
        .ratioSel (oscCtrl[PB_DIV_LSB +: PB_DIV_W]),
        .tick     (periphTick)
    );

    // stop-in-idle gating; all halt in Sleep
    // Registered so a gate never glitches within a cycle
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            periphRun <= '1;
        end else if (next_state == SLEEP || next_state == WAKE) begin
            periphRun <= '0;
        end else if (next_state == IDLE) begin
            periphRun <= ~stopInIdle;
        end else begin
            periphRun <= '1;
        end
    end

    // ------------------------------------------------------------
    // Always-on companions and state flags
    // ------------------------------------------------------------
    // sleep-capable units keep their own clocks
    // Tied on: those units gate themselves from their own sources
    assign sleepPeriphRun = 1'b1;
    // monitor off in Sleep, brownout always on
    assign clockMonitorEn = (state != SLEEP);
    assign brownoutEn     = 1'b1;
    assign watchdogClear  = 1'b0;
    // pads keep driving; hold flag only informs the pad ring
    assign padHold        = (state == SLEEP);
    assign inIdle         = (state == IDLE);
    assign inSleep        = (state == SLEEP);
endmodule
`default_nettype wire

// ==== common/power_ctl_pkg.sv ====
package power_ctl_pkg;

    // ------------------------------------------------------------
    // Register map (byte addresses, one word each)
    // ------------------------------------------------------------
    localparam logic [7:0] OSC_CTRL_ADDR   = 8'h00;
    localparam logic [7:0] STOP_IDLE_ADDR  = 8'h04;
    localparam logic [7:0] STATUS_ADDR     = 8'h08;

    // ------------------------------------------------------------
    // Oscillator control fields
    // ------------------------------------------------------------
    localparam int SRC_LSB        = 0;
    localparam int SRC_W          = 3;
    localparam int SLEEP_SEL_BIT  = 4;
    localparam int USB_HOLD_BIT   = 5;
    localparam int PB_DIV_LSB     = 19;
    localparam int PB_DIV_W       = 2;
    localparam int PRIO_W         = 3;

    // Clock source codes
    localparam logic [2:0] SRC_FAST_INT   = 3'h0;
    localparam logic [2:0] SRC_FAST_PLL   = 3'h1;
    localparam logic [2:0] SRC_PRIMARY    = 3'h2;
    localparam logic [2:0] SRC_PRIM_PLL   = 3'h3;
    localparam logic [2:0] SRC_SECONDARY  = 3'h4;
    localparam logic [2:0] SRC_LOW_POWER  = 3'h5;
    localparam logic [2:0] SRC_FAST_DIV   = 3'h7;

    localparam logic [31:0] OSC_CTRL_RESET = 32'h0000_0000;

    // ------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------
    localparam int CLK_MHZ        = 100;
    localparam int OSC_START_US   = 1024;
    localparam int PLL_LOCK_US    = 100;
    localparam int OSC_START_CYC  = OSC_START_US * CLK_MHZ;
    localparam int PLL_LOCK_CYC   = PLL_LOCK_US * CLK_MHZ;
    localparam int DELAY_W        = 20;

    // Power states, one-hot
    typedef enum logic [3:0] {
        RUN   = 4'b0001,
        IDLE  = 4'b0010,
        SLEEP = 4'b0100,
        WAKE  = 4'b1000
    } power_state_t;

endpackage

// ==== verilog/ratio_divider.sv ====
`timescale 1ns/1ps
`default_nettype none
// ------------------------------------------------------------
// Clock-enable pulse at one of 1/1, 1/2, 1/4, 1/8
// ------------------------------------------------------------
module ratio_divider (
    input  wire logic       clk,
    input  wire logic       rst_n,
    input  wire logic       run,
    input  wire logic [1:0] ratioSel,
    output logic            tick
);
    logic [2:0] count;
    logic [2:0] limit;

    // Terminal count from the select code
    assign limit = 3'(({2'b0, 1'b1} << ratioSel) - 3'h1);

    // Free count while running; held when stopped
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            count <= 3'h0;
            tick  <= 1'b0;
        end else if (!run) begin
            tick  <= 1'b0;
        end else if (count >= limit) begin
            count <= 3'h0;
            tick  <= 1'b1;
        end else begin
            count <= 3'(count + 3'h1);
            tick  <= 1'b0;
        end
    end
endmodule
`default_nettype wire

// ==== tb/power_ctl_monitor.sv ====
`timescale 1ns/1ps
`default_nettype none
// ------------------------------------------------------------
// Power state checker
// ------------------------------------------------------------
module power_ctl_monitor (
    input wire logic                             clk,
    input wire logic                             rst_n,
    input wire logic                             haltInstr,
    input wire logic                             irqPending,
    input wire logic [power_ctl_pkg::PRIO_W-1:0] irqPriority,
    input wire logic                             irqSleepCapable,
    input wire logic [power_ctl_pkg::PRIO_W-1:0] cpuPriority,
    input wire logic                             watchdogTimeout,
    input wire logic                             usbOscRequest,
    input wire logic                             cpuClkEn,
    input wire logic                             sysSourceEn,
    input wire logic                             periphTick,
    input wire logic                             clockMonitorEn,
    input wire logic                             brownoutEn,
    input wire logic                             watchdogClear,
    input wire logic                             padHold,
    input wire logic                             inIdle,
    input wire logic                             inSleep
);
    import power_ctl_pkg::*;
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n);
    a_cpu_clk_gated: assert property ((inIdle || inSleep) |-> !cpuClkEn)
        else $error("CPU clock runs while halted");
    a_idle_src_on: assert property (inIdle |-> sysSourceEn)
        else $error("system source off in idle");
    a_halt_entry: assert property (cpuClkEn && haltInstr |=> inIdle || inSleep)
        else $error("halt did not stop the CPU");
    a_idle_hold: assert property (inIdle && irqPending && irqPriority <= cpuPriority
        && !watchdogTimeout |=> inIdle) else $error("idle left on low priority");
    a_idle_wake: assert property (inIdle && (watchdogTimeout || irqPending
        && irqPriority > cpuPriority) |-> ##[1:2] cpuClkEn) else $error("idle wake missed");
    a_sleep_src_off: assert property (inSleep && $past(inSleep) && !usbOscRequest
        && !$past(usbOscRequest) |-> !sysSourceEn && !periphTick) else $error("clock runs in sleep");
    a_sleep_outputs: assert property (inSleep |-> !clockMonitorEn && brownoutEn && padHold)
        else $error("sleep monitor or pad state wrong");
    a_wdt_kept: assert property ($rose(inSleep) |-> !watchdogClear [*2])
        else $error("watchdog cleared on sleep entry");
    a_sleep_low_idle: assert property (inSleep && irqPending && irqSleepCapable
        && irqPriority <= cpuPriority && !watchdogTimeout |=> inIdle) else $error("no idle on low wake");
    a_sleep_wake: assert property (inSleep && (watchdogTimeout || irqPending && irqSleepCapable
        && irqPriority > cpuPriority) |=> !inSleep && !inIdle) else $error("sleep wake missed");
endmodule

bind sleep_idle_power_control power_ctl_monitor u_power_ctl_monitor (.clk(clk), .rst_n(rst_n),
    .haltInstr(haltInstr), .irqPending(irqPending), .irqPriority(irqPriority),
    .irqSleepCapable(irqSleepCapable), .cpuPriority(cpuPriority), .watchdogTimeout(watchdogTimeout),
    .usbOscRequest(usbOscRequest), .cpuClkEn(cpuClkEn), .sysSourceEn(sysSourceEn),
    .periphTick(periphTick), .clockMonitorEn(clockMonitorEn), .brownoutEn(brownoutEn),
    .watchdogClear(watchdogClear), .padHold(padHold), .inIdle(inIdle), .inSleep(inSleep));
`default_nettype wire

// ==== tb/cpu_irq_model.sv ====
`timescale 1ns/1ps
`default_nettype none
// ------------------------------------------------------------
// CPU core and interrupt controller model
// ------------------------------------------------------------
module cpu_irq_model (
    input  wire logic                        clk,
    output logic                             haltInstr,
    output logic                             irqPending,
    output logic [power_ctl_pkg::PRIO_W-1:0] irqPriority,
    output logic                             irqSleepCapable,
    output logic [power_ctl_pkg::PRIO_W-1:0] cpuPriority,
    output logic                             watchdogTimeout
);
    import power_ctl_pkg::*;
    // Quiet at start, CPU at mid priority
    initial begin
        haltInstr = 1'b0;
        {irqPending, irqPriority, irqSleepCapable, watchdogTimeout} = '0;
        cpuPriority = 3'h3;
    end
    // Wait instruction lasts one cycle
    task automatic halt();
        @(posedge clk);
        haltInstr <= 1'b1;
        @(posedge clk);
        haltInstr <= 1'b0;
    endtask
    // Levels held until the next call, as a real controller would
    task automatic irq(input logic on, input logic [2:0] p, input logic cap, input logic wdt);
        @(posedge clk);
        {irqPending, irqPriority, irqSleepCapable, watchdogTimeout} <= {on, p, cap, wdt};
    endtask
endmodule
`default_nettype wire

// ==== tb/sleep_idle_power_control_bench.sv ====
`timescale 1ns/1ps
`default_nettype none
// ------------------------------------------------------------
// Bench top
// ------------------------------------------------------------
module sleep_idle_power_control_bench;
    import power_ctl_pkg::*;
    localparam int OSC_N = 5;
    localparam int PLL_N = 3;
    logic        clk, pready, pslverr, err, haltInstr, irqPending, irqSleepCapable, watchdogTimeout;
    logic        rst_n = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, usbOscRequest = 1'b0;
    logic        cpuClkEn, sysSourceEn, periphTick, sleepPeriphRun, clockMonitorEn;
    logic        brownoutEn, watchdogClear, padHold, inIdle, inSleep;
    logic [7:0]  paddr = 8'h00, periphRun;
    logic [31:0] pwdata = 32'h0, prdata, rd;
    logic [2:0]  irqPriority, cpuPriority, clkSource;
    logic [2:0]  srcs [4] = '{SRC_FAST_INT, SRC_LOW_POWER, SRC_SECONDARY, SRC_FAST_DIV};
    int          n_fail = 0, n_compared = 0, cnt;

    sleep_idle_power_control #(.NUM_PERIPH(8), .OSC_START_CNT(OSC_N), .PLL_LOCK_CNT(PLL_N))
    u_sleep_idle_power_control (.clk(clk), .rst_n(rst_n), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .haltInstr(haltInstr), .irqPending(irqPending), .irqPriority(irqPriority),
        .irqSleepCapable(irqSleepCapable), .cpuPriority(cpuPriority), .watchdogTimeout(watchdogTimeout),
        .usbOscRequest(usbOscRequest), .cpuClkEn(cpuClkEn), .sysSourceEn(sysSourceEn),
        .clkSource(clkSource), .periphTick(periphTick), .periphRun(periphRun),
        .sleepPeriphRun(sleepPeriphRun), .clockMonitorEn(clockMonitorEn), .brownoutEn(brownoutEn),
        .watchdogClear(watchdogClear), .padHold(padHold), .inIdle(inIdle), .inSleep(inSleep));
    cpu_irq_model u_cpu_irq_model (.clk(clk), .haltInstr(haltInstr), .irqPending(irqPending),
        .irqPriority(irqPriority), .irqSleepCapable(irqSleepCapable), .cpuPriority(cpuPriority),
        .watchdogTimeout(watchdogTimeout));

    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    // Whole-run guard against a hang
    initial begin
        repeat (20000) @(posedge clk);
        n_fail++;
        print_verdict();
    end

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            n_fail++;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic print_verdict();
        $display("compared %0d mismatches %0d", n_compared, n_fail);
        if (n_fail == 0 && n_compared > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask
    // Setup then access; held until pready is seen at an edge
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        int i;
        @(posedge clk);
        {psel, pwrite, paddr, pwdata} <= {1'b1, wr, a, d};
        @(posedge clk);
        penable <= 1'b1;
        for (i = 0; i < 8; i++) begin
            @(posedge clk);
            if (pready === 1'b1) break;
        end
        rd = prdata;
        err = pslverr;
        {psel, penable} <= 2'b00;
        if (i == 8) begin
            n_fail++;
            print_verdict();
        end
    endtask
    // Sample away from the edge so updates have landed
    task automatic ticks(input int n);
        repeat (n) @(posedge clk);
        @(negedge clk);
    endtask
    task automatic do_reset(input int n);
        @(posedge clk);
        rst_n <= 1'b0;
        repeat (n) @(posedge clk);
        rst_n <= 1'b1;
    endtask
    // Sleep, wake on a high interrupt, time the restart
    task automatic sleep_wake(input logic [31:0] osc, input int lo);
        apb(1'b1, OSC_CTRL_ADDR, osc);
        u_cpu_irq_model.halt();
        ticks(2);
        check(inSleep, 1'b1);
        check({clockMonitorEn, brownoutEn, padHold, watchdogClear}, 4'b0110);
        check(sleepPeriphRun, 1'b1);
        check(sysSourceEn, usbOscRequest & osc[USB_HOLD_BIT]);
        u_cpu_irq_model.irq(1'b1, 3'h6, 1'b1, 1'b0);
        cnt = 0;
        while (cpuClkEn !== 1'b1 && cnt < 40) begin
            @(negedge clk);
            cnt++;
        end
        check(cnt >= lo + 1 && cnt <= lo + 4, 1'b1);
        if (cnt >= 40) print_verdict();
        apb(1'b0, STATUS_ADDR, 32'h0);
        check(rd, {25'h0, osc[2:0], 4'h1});
        u_cpu_irq_model.irq(1'b0, 3'h0, 1'b0, 1'b0);
    endtask

    initial begin
        do_reset(5);
        apb(1'b0, OSC_CTRL_ADDR, 32'h0);
        check(rd, OSC_CTRL_RESET);
        apb(1'b0, 8'h0C, 32'h0);
        check(32'(err), 32'h1);
        check(rd, 32'h0);
        check({cpuClkEn, sysSourceEn, periphRun}, 10'h3FF);
        $display("reset test done");
        // Each divisor ratio, with a run source picked at the same time
        for (int d = 0; d < 4; d++) begin
            apb(1'b1, OSC_CTRL_ADDR, (d << PB_DIV_LSB) | srcs[d]);
            ticks(8);
            check(clkSource, srcs[d]);
            cnt = 0;
            repeat (32) begin
                @(negedge clk);
                cnt += periphTick;
            end
            check(cnt, 32 >> d);
        end
        $display("divisor test done");
        apb(1'b1, STOP_IDLE_ADDR, 32'hA5);
        apb(1'b1, OSC_CTRL_ADDR, 32'h0);
        u_cpu_irq_model.halt();
        u_cpu_irq_model.irq(1'b1, 3'h3, 1'b0, 1'b0);
        ticks(3);
        check(inIdle, 1'b1);
        check(periphRun, 8'h5A);
        check({cpuClkEn, sysSourceEn}, 2'b01);
        cnt = 0;
        repeat (8) begin
            @(negedge clk);
            cnt += periphTick;
        end
        check(cnt, 8);
        u_cpu_irq_model.irq(1'b1, 3'h4, 1'b0, 1'b0);
        ticks(2);
        check(cpuClkEn, 1'b1);
        u_cpu_irq_model.irq(1'b0, 3'h0, 1'b0, 1'b0);
        u_cpu_irq_model.halt();
        u_cpu_irq_model.irq(1'b0, 3'h0, 1'b0, 1'b1);
        ticks(2);
        check(cpuClkEn, 1'b1);
        u_cpu_irq_model.irq(1'b0, 3'h0, 1'b0, 1'b0);
        $display("idle test done");
        apb(1'b1, OSC_CTRL_ADDR, 32'h10);
        u_cpu_irq_model.halt();
        u_cpu_irq_model.irq(1'b1, 3'h2, 1'b1, 1'b0);
        ticks(2);
        check({inIdle, cpuClkEn}, 2'b10);
        cnt = 0;
        repeat (4) begin
            @(negedge clk);
            cnt += periphTick;
        end
        check(cnt, 4);
        u_cpu_irq_model.irq(1'b0, 3'h0, 1'b0, 1'b0);
        do_reset(2);
        ticks(1);
        check(cpuClkEn, 1'b1);
        apb(1'b0, STOP_IDLE_ADDR, 32'h0);
        check(rd, 32'h0);
        $display("sleep to idle test done");
        sleep_wake(32'h10, 0);
        sleep_wake(32'h13, OSC_N + PLL_N);
        usbOscRequest <= 1'b1;
        sleep_wake(32'h33, 0);
        $display("sleep wake test done");
        print_verdict();
    end
endmodule
`default_nettype wire
